// ### dv/tb_shift_flag_skip_exec.sv
// self-checking bench for the shift, flag and skip execution block
`timescale 1ns/100ps
`include "ssx_map.svh"
module tb_shift_flag_skip_exec;
  logic        core_clk_in    = 1'b0;
  logic        reset_in       = 1'b1;
  logic        instr_valid_in = 1'b0;
  logic [15:0] instr_word_in  = 16'h0000;
  logic        load_en_in     = 1'b0;
  logic [6:0]  load_addr_in   = 7'h00;
  logic [3:0]  load_data_in   = 4'h0;
  logic        busy_out, done_out, carry_flag_out, zero_flag_out, wdt_tick_out;
  logic [3:0]  accumulator_nibble_out, parameter_flags_out;
  logic [10:0] program_counter_out;
  logic [3:0]  mem_m [128];
  logic [10:0] e_pc = 11'h000;
  logic        e_c = 1'b0;
  logic        e_z = 1'b0;
  logic [3:0]  e_acc = 4'h0;
  logic [3:0]  e_pflag = 4'h0;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          per;

  // short divider counts keep the watchdog checks quick
  ssx_exec #(.WDT_DIV_HIGH(16), .WDT_DIV_LOW(8)) ssx_exec_i (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in), .load_en_in(load_en_in), .load_addr_in(load_addr_in),
    .load_data_in(load_data_in), .busy_out(busy_out), .done_out(done_out),
    .carry_flag_out(carry_flag_out), .zero_flag_out(zero_flag_out),
    .accumulator_nibble_out(accumulator_nibble_out),
    .program_counter_out(program_counter_out),
    .parameter_flags_out(parameter_flags_out), .wdt_tick_out(wdt_tick_out));

  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end

  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end

  task automatic cmp_bit(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %b got %b", nm, exp, got);
    end
  endtask

  task automatic cmp_vec(input string nm, input logic [10:0] exp, input logic [10:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic check_all();
    cmp_bit("carry", e_c, carry_flag_out);
    cmp_bit("zero", e_z, zero_flag_out);
    cmp_vec("acc", 11'(e_acc), 11'(accumulator_nibble_out));
    cmp_vec("pc", e_pc, program_counter_out);
    cmp_vec("pflags", 11'(e_pflag), 11'(parameter_flags_out));
  endtask

  // all tasks start and end on a falling edge
  task automatic preload(input logic [6:0] a, input logic [3:0] d);
    load_en_in = 1'b1;
    load_addr_in = a;
    load_data_in = d;
    @(negedge core_clk_in);
    load_en_in = 1'b0;
    mem_m[a] = d;
    // let an edge pass so back-to-back loads never drive the strobe twice at once
    @(negedge core_clk_in);
  endtask

  task automatic run(input logic [15:0] w);
    int k;
    instr_word_in = w;
    instr_valid_in = 1'b1;
    @(negedge core_clk_in);
    instr_valid_in = 1'b0;
    cmp_bit("busy", 1'b1, busy_out);
    k = 0;
    while (done_out !== 1'b1 && k < 4) begin
      @(negedge core_clk_in);
      k++;
    end
    cmp_bit("done", 1'b1, done_out);
    e_pc = e_pc + `SSX_STEP_ONE;
  endtask

  task automatic shift(input logic left, input logic [6:0] a);
    logic [3:0] v;
    v = mem_m[a];
    run({(left ? `SSX_SHL_PRE : `SSX_SHR_PRE), a});
    e_c = left ? v[3] : v[0];
    e_acc = left ? {v[2:0], 1'b0} : {1'b0, v[3:1]};
    e_z = (e_acc === `SSX_NIB_ZERO);
    mem_m[a] = e_acc;
    check_all();
  endtask

  task automatic skip(input logic b1, input logic [6:0] a);
    run({(b1 ? `SSX_SKIP1_PRE : `SSX_SKIP0_PRE), a});
    if (b1 ? mem_m[a][1] : mem_m[a][0]) e_pc = e_pc + `SSX_STEP_ONE;
    check_all();
  endtask

  task automatic tick_gap(output int n);
    while (wdt_tick_out !== 1'b1) @(negedge core_clk_in);
    @(negedge core_clk_in);
    n = 1;
    while (wdt_tick_out !== 1'b1 && n < 64) begin
      @(negedge core_clk_in);
      n++;
    end
  endtask

  initial begin
    logic [6:0] adr [4];
    logic [3:0] val [4];
    adr = '{7'h00, 7'h7F, 7'h2A, 7'h55};
    val = '{4'h9, 4'h8, 4'h1, 4'hE};
    repeat (12) @(negedge core_clk_in);
    reset_in = 1'b0;
    for (int i = 0; i < 4; i++) preload(adr[i], val[i]);
    // a second shift of the same place proves the write-back
    for (int i = 0; i < 4; i++) begin
      shift(1'b1, adr[i]);
      shift(1'b0, adr[i]);
      shift(1'b0, adr[i]);
    end
    $display("test shifts done");
    preload(7'h40, 4'h0);
    shift(1'b0, 7'h40);
    run(`SSX_SETC_WORD);
    e_c = 1'b1;
    check_all();
    $display("test set carry done");
    for (int v = 0; v < 4; v++) begin
      preload(7'h33, 4'(v));
      skip(1'b0, 7'h33);
      skip(1'b1, 7'h33);
    end
    $display("test skips done");
    run({`SSX_PFLAG_HIGH, 8'h07});
    check_all();
    tick_gap(per);
    tick_gap(per);
    cmp_vec("tick gap", 11'h008, 11'(per));
    run({`SSX_PFLAG_HIGH, 8'h0F});
    e_pflag = 4'h8;
    check_all();
    tick_gap(per);
    tick_gap(per);
    cmp_vec("tick gap", 11'h010, 11'(per));
    $display("test parameter flags done");
    close_out();
  end
endmodule

// ### hw/ssx_exec.sv
// execution of set-carry, parameter flags, zero-fill shifts and bit skips
// Operation
// - set carry to one, nothing else changes but the program counter, which steps by one
// - flag bit three picks osc over 16384
// - flag bits zero to two ignored
// - shift left, old bit3 to carry, zero in
// - shift right, old bit0 to carry, zero in
// - skip two when nibble bit0 set
// - skip two when nibble bit1 set
// - memory operand from 7-bit low address field
`timescale 1ns/100ps
`include "ssx_map.svh"
module ssx_exec #(
  parameter int WDT_DIV_HIGH = 16384,
  parameter int WDT_DIV_LOW  = 1024
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      instr_valid_in,
  input  wire logic [15:0]               instr_word_in,
  input  wire logic                      load_en_in,
  input  wire logic [`SSX_ADDR_W-1:0]    load_addr_in,
  input  wire logic [`SSX_NIB_W-1:0]     load_data_in,
  output logic                           busy_out,
  output logic                           done_out,
  output logic                           carry_flag_out,
  output logic                           zero_flag_out,
  output logic [`SSX_NIB_W-1:0]          accumulator_nibble_out,
  output logic [`SSX_PC_W-1:0]           program_counter_out,
  output logic [`SSX_NIB_W-1:0]          parameter_flags_out,
  output logic                           wdt_tick_out
);
  import ssx_pkg::*;

  ssx_mem_if mem_bus ();

  ssx_state_t             state_ff;
  ssx_op_t                op_ff;
  ssx_op_t                dec_op;
  logic [`SSX_ADDR_W-1:0] addr_ff;
  logic [`SSX_NIB_W-1:0]  imm_ff;
  logic [`SSX_NIB_W-1:0]  shift_res;
  logic                   shift_cy;
  logic                   accept;
  logic                   exec;
  logic                   is_shift;
  logic [`SSX_DIV_W-1:0]  div_cnt_ff;
  logic [`SSX_DIV_W-1:0]  div_last;

  function automatic ssx_op_t decode_op(input logic [15:0] w);
    ssx_op_t res;
    res = SSX_OP_NONE;
    if (w == `SSX_SETC_WORD) begin
      res = SSX_OP_SETC;
    end else if (w[15:8] == `SSX_PFLAG_HIGH) begin
      res = SSX_OP_PFLAG;
    end else if (w[15:7] == `SSX_SHL_PRE) begin
      res = SSX_OP_SHL;
    end else if (w[15:7] == `SSX_SHR_PRE) begin
      res = SSX_OP_SHR;
    end else if (w[15:7] == `SSX_SKIP0_PRE) begin
      res = SSX_OP_SKIP0;
    end else if (w[15:7] == `SSX_SKIP1_PRE) begin
      res = SSX_OP_SKIP1;
    end
    return res;
  endfunction

  assign dec_op   = decode_op(instr_word_in);
  assign accept   = instr_valid_in && (state_ff == SSX_IDLE);
  assign exec     = (state_ff == SSX_EXEC);
  assign is_shift = (op_ff == SSX_OP_SHL) || (op_ff == SSX_OP_SHR);

  always_comb begin
    shift_res = mem_bus.rdata;
    shift_cy  = 1'b0;
    if (op_ff == SSX_OP_SHL) begin
      shift_res = {mem_bus.rdata[2:0], 1'b0};
      shift_cy  = mem_bus.rdata[3];
    end else if (op_ff == SSX_OP_SHR) begin
      shift_res = {1'b0, mem_bus.rdata[3:1]};
      shift_cy  = mem_bus.rdata[0];
    end
  end

  // address comes straight off the word while idle, unless an idle preload write takes the port, so read data is ready next cycle
  always_comb begin
    mem_bus.addr  = exec ? addr_ff : instr_word_in[`SSX_ADDR_W-1:0];
    mem_bus.we    = exec && is_shift;
    mem_bus.wdata = shift_res;
    if (!exec && !accept && load_en_in) begin
      mem_bus.addr  = load_addr_in;
      mem_bus.we    = 1'b1;
      mem_bus.wdata = load_data_in;
    end
  end

  ssx_nibble_mem #(
    .DEPTH (1 << `SSX_ADDR_W)
  ) u_mem (
    .core_clk_in (core_clk_in),
    .bus         (mem_bus.mem)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_ff <= SSX_IDLE;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      state_ff <= accept ? SSX_EXEC : SSX_IDLE;
      busy_out <= accept;
      done_out <= exec;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      op_ff   <= SSX_OP_NONE;
      addr_ff <= '0;
      imm_ff  <= `SSX_NIB_ZERO;
    end else if (accept) begin
      op_ff   <= dec_op;
      addr_ff <= instr_word_in[`SSX_ADDR_W-1:0];
      imm_ff  <= instr_word_in[`SSX_NIB_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      carry_flag_out         <= 1'b0;
      zero_flag_out          <= 1'b0;
      accumulator_nibble_out <= `SSX_NIB_ZERO;
    end else if (exec && op_ff == SSX_OP_SETC) begin
      carry_flag_out <= 1'b1;
    end else if (exec && is_shift) begin
      carry_flag_out         <= shift_cy;
      accumulator_nibble_out <= shift_res;
      zero_flag_out          <= (shift_res == `SSX_NIB_ZERO);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      parameter_flags_out <= `SSX_PFLAG_RESET;
    end else if (exec && op_ff == SSX_OP_PFLAG) begin
      // low three immediate bits carry no function, so they are not kept
      parameter_flags_out <= {imm_ff[`SSX_PFLAG_WDT_BIT], 3'b000};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      program_counter_out <= `SSX_PC_RESET;
    end else if (exec) begin
      if ((op_ff == SSX_OP_SKIP0 && mem_bus.rdata[0]) ||
          (op_ff == SSX_OP_SKIP1 && mem_bus.rdata[1])) begin
        program_counter_out <= program_counter_out + `SSX_STEP_TWO;
      end else begin
        program_counter_out <= program_counter_out + `SSX_STEP_ONE;
      end
    end
  end

  // watchdog input tick; a change of source applies to the wrap compare at once, so a count past the new limit wraps on the next edge
  assign div_last = parameter_flags_out[`SSX_PFLAG_WDT_BIT] ?
                    `SSX_DIV_W'(WDT_DIV_HIGH - 1) : `SSX_DIV_W'(WDT_DIV_LOW - 1);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      div_cnt_ff   <= `SSX_DIV_ZERO;
      wdt_tick_out <= 1'b0;
    end else if (div_cnt_ff >= div_last) begin
      div_cnt_ff   <= `SSX_DIV_ZERO;
      wdt_tick_out <= 1'b1;
    end else begin
      div_cnt_ff   <= div_cnt_ff + `SSX_DIV_ONE;
      wdt_tick_out <= 1'b0;
    end
  end

  sequence seq_accept_op(ssx_op_t o);
    accept && dec_op == o;
  endsequence

  sequence seq_exec_op(ssx_op_t o);
    exec && op_ff == o;
  endsequence

  chk_setc_only_carry: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_exec_op(SSX_OP_SETC) |=> carry_flag_out && $stable(accumulator_nibble_out)
      && $stable(zero_flag_out) && $stable(parameter_flags_out))
    else $error("set carry did not set carry alone");

  chk_wdt_slow_period: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (wdt_tick_out && $past(parameter_flags_out[`SSX_PFLAG_WDT_BIT]) &&
     $past(parameter_flags_out[`SSX_PFLAG_WDT_BIT], 2))
      |-> $past(div_cnt_ff) == `SSX_DIV_W'(WDT_DIV_HIGH - 1))
    else $error("watchdog tick not at slow divide");

  chk_pflag_reserved_bits: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_accept_op(SSX_OP_PFLAG) |=> ##1 parameter_flags_out ==
      {$past(instr_word_in[`SSX_PFLAG_WDT_BIT], 2), 3'b000})
    else $error("parameter flags wrong after write");

  chk_shl_result: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_exec_op(SSX_OP_SHL) |=> accumulator_nibble_out == {$past(mem_bus.rdata[2:0]), 1'b0}
      && carry_flag_out == $past(mem_bus.rdata[3]))
    else $error("shift left result wrong");

  chk_shr_result: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_exec_op(SSX_OP_SHR) |=> accumulator_nibble_out == {1'b0, $past(mem_bus.rdata[3:1])}
      && carry_flag_out == $past(mem_bus.rdata[0]))
    else $error("shift right result wrong");

  chk_skip_bit0: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_exec_op(SSX_OP_SKIP0) |=> program_counter_out == $past(program_counter_out) +
      ($past(mem_bus.rdata[0]) ? `SSX_STEP_TWO : `SSX_STEP_ONE))
    else $error("skip on bit 0 wrong step");

  chk_skip_bit1: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_exec_op(SSX_OP_SKIP1) |=> program_counter_out == $past(program_counter_out) +
      ($past(mem_bus.rdata[1]) ? `SSX_STEP_TWO : `SSX_STEP_ONE))
    else $error("skip on bit 1 wrong step");

  chk_operand_addr: assert property (@(posedge core_clk_in) disable iff (reset_in)
    accept |-> mem_bus.addr == instr_word_in[`SSX_ADDR_W-1:0] ##1
      (exec && mem_bus.addr == $past(instr_word_in[`SSX_ADDR_W-1:0])) ##1 done_out)
    else $error("operand address not from low field");

  chk_zero_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (exec && is_shift) |=> zero_flag_out == (accumulator_nibble_out == `SSX_NIB_ZERO))
    else $error("zero flag disagrees with result");
endmodule

// ### hw/ssx_map.svh
// constant map for the shift, flag and skip execution block
`ifndef SSX_MAP_SVH
`define SSX_MAP_SVH
`define SSX_ADDR_W        7
`define SSX_NIB_W         4
`define SSX_PC_W          11
`define SSX_PRE_W         9
`define SSX_SETC_WORD     16'h5000
`define SSX_PFLAG_HIGH    8'h16
`define SSX_SHL_PRE       9'h098
`define SSX_SHR_PRE       9'h09A
`define SSX_SKIP0_PRE     9'h110
`define SSX_SKIP1_PRE     9'h111
`define SSX_PFLAG_WDT_BIT 3
`define SSX_STEP_ONE      11'h001
`define SSX_STEP_TWO      11'h002
`define SSX_NIB_ZERO      4'h0
`define SSX_PFLAG_RESET   4'h0
`define SSX_PC_RESET      11'h000
`define SSX_DIV_W         14
`define SSX_DIV_ZERO      14'h0000
`define SSX_DIV_ONE       14'h0001
`endif

// ### hw/ssx_mem_if.sv
// data memory port between the executor and the nibble memory
`timescale 1ns/100ps
interface ssx_mem_if;
  logic       we;
  logic [6:0] addr;
  logic [3:0] wdata;
  logic [3:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ### hw/ssx_nibble_mem.sv
// 128 x 4 data memory with registered read
`timescale 1ns/100ps
`include "ssx_map.svh"
module ssx_nibble_mem #(
  parameter int DEPTH = 128
) (
  input  wire logic  core_clk_in,
  ssx_mem_if.mem     bus
);
  logic [`SSX_NIB_W-1:0] store_ff [DEPTH];

  always_ff @(posedge core_clk_in) begin
    if (bus.we) begin
      store_ff[bus.addr] <= bus.wdata;
    end
  end

  // read before write: the executor wants the old nibble
  always_ff @(posedge core_clk_in) begin
    bus.rdata <= store_ff[bus.addr];
  end
endmodule

// ### hw/ssx_pkg.sv
// types used by the execution block for its state and its decoded operation
package ssx_pkg;
  typedef enum logic [0:0] {
    SSX_IDLE = 1'b0,
    SSX_EXEC = 1'b1
  } ssx_state_t;

  typedef enum logic [2:0] {
    SSX_OP_NONE = 3'b000,
    SSX_OP_SETC = 3'b001,
    SSX_OP_PFLAG = 3'b010,
    SSX_OP_SHL   = 3'b011,
    SSX_OP_SHR   = 3'b100,
    SSX_OP_SKIP0 = 3'b101,
    SSX_OP_SKIP1 = 3'b110
  } ssx_op_t;
endpackage
